/* File: core/rpm_pkg.sv */
package rpm_pkg;
   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam logic [7:0] RPM_STATUS_OFS  = 8'h2C;
   localparam logic [7:0] RPM_CTRL_OFS    = 8'h30;
   localparam logic [7:0] RPM_MODE_OFS    = 8'h34;
   // status bit positions
   localparam int RPM_SLEEP_BIT  = 7;
   localparam int RPM_TOUT_BIT   = 6;
   localparam int RPM_IDLE_BIT   = 5;
   localparam int RPM_BOR_BIT    = 4;
   localparam int RPM_STACK_ERROR_FLAG_BIT  = 2;
   localparam logic [7:0] RPM_STATUS_MASK = 8'hF4;
   // ctrl bit positions
   localparam int RPM_CTRL_IDLE  = 0;
   localparam int RPM_CTRL_SLEEP = 1;
   // ----------------------------------------
   // vectors and timing
   // ----------------------------------------
   localparam logic [12:0] RPM_RESET_VEC = 13'h0000;
   localparam logic [12:0] RPM_IRQ_VEC   = 13'h0004;
   localparam int RPM_LS_CYCLES = 2048;
   localparam int RPM_HS_CYCLES = 1024;
   localparam logic [1:0] RPM_RESP_OKAY   = 2'h0;
   localparam logic [1:0] RPM_RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {RPM_RUN, RPM_IDLE, RPM_SLEEP} rpm_mode_e;
   typedef enum logic [1:0] {RPM_READY, RPM_WAIT_LS, RPM_WAIT_HS} rpm_seq_e;
endpackage : rpm_pkg

/* File: core/rpm_ctrl.sv */
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/10ps
// Summary of operation
// - run mode: cpu executes and every peripheral keeps running
// - idle instruction halts cpu, peripherals run, sets idle flag
// - watchdog expiry in idle wakes cpu as interrupt, not reset
// - sleep instruction stops cpu and all oscillators, sets sleep flag
// - interrupt from a still-running peripheral wakes chip from sleep
// - wake by interrupt loads program counter with interrupt vector
// - exactly four reset sources: brown-out, pin, watchdog, stack error
// - after any reset the cpu fetches from address zero
// - brown-out and pin resets hold cpu until start-up count ends
// - watchdog and stack resets restart quickly without start-up count
// - start-up delay is 2048 low-speed then 1024 high-speed cycles
// - reset validity per mode: watchdog not in sleep, stack run only
// - brown-out held while supply low, sets flag, cannot be disabled
// - pin reset held while pin low, start-up count runs once pin returns high
// - watchdog expiry in run gives quick reset and sets timeout flag
// - stack overflow or underflow gives quick reset, sets stack flag
// - per-source flag effects: brown-out, pin, watchdog, stack
// - four flags cleared by brown-out, pin reset or software zero
// - brown-out flag cleared only by software writing zero
// - low-speed oscillator stops in sleep, restarts on wake
module rpm_ctrl
   import rpm_pkg::*;
#(
   parameter int LS_CYCLES = RPM_LS_CYCLES,
   parameter int HS_CYCLES = RPM_HS_CYCLES
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        aclk_en,
   // axi4-lite slave
   input  wire logic [7:0]  s_awaddr,
   input  wire logic        s_awvalid,
   output logic             s_awready,
   input  wire logic [31:0] s_wdata,
   input  wire logic [3:0]  s_wstrb,
   input  wire logic        s_wvalid,
   output logic             s_wready,
   output logic [1:0]       s_bresp,
   output logic             s_bvalid,
   input  wire logic        s_bready,
   input  wire logic [7:0]  s_araddr,
   input  wire logic        s_arvalid,
   output logic             s_arready,
   output logic [31:0]      s_rdata,
   output logic [1:0]       s_rresp,
   output logic             s_rvalid,
   input  wire logic        s_rready,
   // cpu side
   input  wire logic        idle_instr,
   input  wire logic        sleep_instruction,
   input  wire logic        irq_pending,
   input  wire logic        irq_wake_capable,
   input  wire logic        watchdog_timer_expired,
   input  wire logic        stack_error,
   output logic             cpu_halt,
   output logic             cpu_reset,
   output logic             pc_load,
   output logic [12:0]      pc_value,
   output logic             watchdog_irq,
   // reset sources
   input  wire logic        brownout_low,
   input  wire logic        reset_pin_n,
   // oscillators
   input  wire logic        low_speed_rc_osc_tick,
   input  wire logic        high_speed_rc_osc_tick,
   output logic             high_speed_rc_osc_en,
   output logic             low_speed_rc_osc_en,
   output logic             crystal_osc_en,
   output logic             periph_clk_en
);
   // ----------------------------------------
   // decode
   // ----------------------------------------
   rpm_mode_e   mode_reg;
   rpm_mode_e   mode_next;
   rpm_seq_e    seq_reg;
   rpm_seq_e    seq_next;
   logic [11:0] cnt_reg;
   logic [11:0] cnt_next;
   logic [7:0]  status_reg;
   logic [7:0]  status_next;
   logic        quick_reg;

   wire hw_rst   = brownout_low | ~reset_pin_n;
   wire in_run   = (mode_reg == RPM_RUN);
   wire in_idle  = (mode_reg == RPM_IDLE);
   wire in_sleep = (mode_reg == RPM_SLEEP);
   wire wdt_rst  = watchdog_timer_expired & in_run;
   wire stack_error_flag_rst = stack_error & in_run;
   wire quick_rst = (wdt_rst | stack_error_flag_rst) & ~hw_rst;
   wire wake_idle = in_idle & (irq_pending | watchdog_timer_expired);
   wire wake_sleep = in_sleep & irq_pending & irq_wake_capable;
   wire wake     = (wake_idle | wake_sleep) & ~hw_rst;
   wire seq_busy = (seq_reg != RPM_READY);

   // ----------------------------------------
   // axi4-lite slave
   // ----------------------------------------
   logic aw_held;
   logic w_held;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   wire aw_take = s_awvalid & s_awready;
   wire w_take  = s_wvalid & s_wready;
   wire wr_go   = (aw_held | aw_take) & (w_held | w_take) & ~s_bvalid;
   wire [7:0] wa   = aw_take ? s_awaddr : aw_addr;
   wire [31:0] wd  = w_take ? s_wdata : w_data;
   wire [3:0] ws   = w_take ? s_wstrb : w_strb;
   wire wr_status  = wr_go & (wa == RPM_STATUS_OFS) & ws[0];
   wire wr_ok      = (wa == RPM_STATUS_OFS) | (wa == RPM_CTRL_OFS)
                     | (wa == RPM_MODE_OFS);
   wire rd_status  = (s_araddr == RPM_STATUS_OFS);
   wire rd_mode    = (s_araddr == RPM_MODE_OFS);
   wire rd_ok      = rd_status | rd_mode | (s_araddr == RPM_CTRL_OFS);
   wire [31:0] rd_word = rd_status ? {24'h000000, status_reg} :
                         rd_mode ? {28'h0000000, seq_busy,
                                    1'b0, mode_reg} : 32'h00000000;

   assign s_awready = ~aw_held & ~s_bvalid;
   assign s_wready  = ~w_held & ~s_bvalid;
   assign s_arready = ~s_rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held  <= 1'b0;
         w_held   <= 1'b0;
         aw_addr  <= 8'h00;
         w_data   <= 32'h00000000;
         w_strb   <= 4'h0;
         s_bvalid <= 1'b0;
         s_bresp  <= RPM_RESP_OKAY;
         s_rvalid <= 1'b0;
         s_rdata  <= 32'h00000000;
         s_rresp  <= RPM_RESP_OKAY;
      end else if (aclk_en) begin
         if (wr_go) begin
            aw_held  <= 1'b0;
            w_held   <= 1'b0;
            s_bvalid <= 1'b1;
            s_bresp  <= wr_ok ? RPM_RESP_OKAY : RPM_RESP_SLVERR;
         end else begin
            if (aw_take) begin
               aw_held <= 1'b1;
               aw_addr <= s_awaddr;
            end
            if (w_take) begin
               w_held <= 1'b1;
               w_data <= s_wdata;
               w_strb <= s_wstrb;
            end
            if (s_bvalid && s_bready) begin
               s_bvalid <= 1'b0;
            end
         end
         if (s_arvalid && s_arready) begin
            s_rvalid <= 1'b1;
            s_rdata  <= rd_word;
            s_rresp  <= rd_ok ? RPM_RESP_OKAY : RPM_RESP_SLVERR;
         end else if (s_rvalid && s_rready) begin
            s_rvalid <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // status flags
   // ----------------------------------------
   // hardware set wins over a software write of zero in the same cycle
   always_comb begin
      status_next = status_reg;
      if (wr_status) begin
         status_next = status_reg & wd[7:0];
      end
      if (hw_rst) begin
         status_next[RPM_SLEEP_BIT] = 1'b0;
         status_next[RPM_TOUT_BIT]  = 1'b0;
         status_next[RPM_IDLE_BIT]  = 1'b0;
         status_next[RPM_STACK_ERROR_FLAG_BIT] = 1'b0;
      end
      if (brownout_low) begin
         status_next[RPM_BOR_BIT] = 1'b1;
      end
      if (!hw_rst) begin
         if (wdt_rst) begin
            status_next[RPM_TOUT_BIT] = 1'b1;
         end
         if (stack_error_flag_rst) begin
            status_next[RPM_STACK_ERROR_FLAG_BIT] = 1'b1;
         end
         if (in_run && !seq_busy && !quick_rst) begin
            if (sleep_instruction) begin
               status_next[RPM_SLEEP_BIT] = 1'b1;
            end else if (idle_instr) begin
               status_next[RPM_IDLE_BIT] = 1'b1;
            end
         end
      end
      status_next = status_next & RPM_STATUS_MASK;
   end

   // ----------------------------------------
   // mode and start-up sequence
   // ----------------------------------------
   always_comb begin
      mode_next = mode_reg;
      if (hw_rst || quick_rst) begin
         mode_next = RPM_RUN;
      end else if (wake) begin
         mode_next = RPM_RUN;
      end else if (in_run && !seq_busy) begin
         if (sleep_instruction) begin
            mode_next = RPM_SLEEP;
         end else if (idle_instr) begin
            mode_next = RPM_IDLE;
         end
      end
   end

   always_comb begin
      seq_next = seq_reg;
      cnt_next = cnt_reg;
      case (seq_reg)
         RPM_WAIT_LS: begin
            if (low_speed_rc_osc_tick) begin
               if (cnt_reg == 12'(LS_CYCLES - 1)) begin
                  seq_next = RPM_WAIT_HS;
                  cnt_next = 12'h000;
               end else begin
                  cnt_next = cnt_reg + 12'h001;
               end
            end
         end
         RPM_WAIT_HS: begin
            if (high_speed_rc_osc_tick) begin
               if (cnt_reg == 12'(HS_CYCLES - 1)) begin
                  seq_next = RPM_READY;
               end else begin
                  cnt_next = cnt_reg + 12'h001;
               end
            end
         end
         default: begin
            seq_next = RPM_READY;
         end
      endcase
      if (hw_rst) begin
         seq_next = RPM_WAIT_LS;
         cnt_next = 12'h000;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_reg   <= RPM_RUN;
         seq_reg    <= RPM_WAIT_LS;
         cnt_reg    <= 12'h000;
         status_reg <= 8'h00;
         quick_reg  <= 1'b0;
      end else if (aclk_en) begin
         mode_reg   <= mode_next;
         seq_reg    <= seq_next;
         cnt_reg    <= cnt_next;
         status_reg <= status_next;
         quick_reg  <= quick_rst;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   // one combined cpu reset, release fetches from the reset vector
   assign cpu_reset = hw_rst | seq_busy | quick_reg;
   assign cpu_halt  = ~in_run;
   assign pc_load   = cpu_reset | wake;
   assign pc_value  = cpu_reset ? RPM_RESET_VEC : RPM_IRQ_VEC;
   assign watchdog_irq = in_idle & watchdog_timer_expired;
   // oscillators run unless sleeping; counting needs them during reset
   assign low_speed_rc_osc_en  = ~in_sleep | hw_rst;
   assign high_speed_rc_osc_en = ~in_sleep | hw_rst;
   assign crystal_osc_en       = ~in_sleep;
   assign periph_clk_en        = ~in_sleep;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   bor_flag_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
      aclk_en && brownout_low |=> status_reg[RPM_BOR_BIT])
      else $error("brown-out flag not set");
   hw_clears_a: assert property (@(posedge aclk) disable iff (!aresetn)
      aclk_en && hw_rst |=> status_reg[RPM_STACK_ERROR_FLAG_BIT] == 1'b0)
      else $error("stack flag survived hardware reset");
   bor_sticky_a: assert property (@(posedge aclk) disable iff (!aresetn)
      aclk_en && status_reg[RPM_BOR_BIT] && !wr_status
      |=> status_reg[RPM_BOR_BIT])
      else $error("brown-out flag lost without write");
   wdt_quick_a: assert property (@(posedge aclk) disable iff (!aresetn)
      aclk_en && wdt_rst && !hw_rst
      |=> status_reg[RPM_TOUT_BIT] && cpu_reset)
      else $error("watchdog reset missing");
   idle_wdt_irq_a: assert property (@(posedge aclk) disable iff (!aresetn)
      in_idle && watchdog_timer_expired
      |-> watchdog_irq && !wdt_rst)
      else $error("watchdog in idle became reset");
   stack_error_flag_run_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !in_run |-> !stack_error_flag_rst)
      else $error("stack reset outside run");
   sleep_osc_a: assert property (@(posedge aclk) disable iff (!aresetn)
      in_sleep && !hw_rst |-> !low_speed_rc_osc_en)
      else $error("oscillator running in sleep");
   hold_reset_a: assert property (@(posedge aclk) disable iff (!aresetn)
      aclk_en && hw_rst |=> seq_reg == RPM_WAIT_LS && cpu_reset)
      else $error("start-up count not restarted");
   wake_vec_a: assert property (@(posedge aclk) disable iff (!aresetn)
      wake && !cpu_reset |-> pc_load && pc_value == RPM_IRQ_VEC)
      else $error("wake vector wrong");

   // ----------------------------------------
   // mode, vector and count checks
   // ----------------------------------------
   idle_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
      aclk_en && !hw_rst && !quick_rst && in_run && !seq_busy
      && idle_instr && !sleep_instruction
      |=> status_reg[RPM_IDLE_BIT] && in_idle)
      else $error("idle entry missing");
   sleep_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
      aclk_en && !hw_rst && !quick_rst && in_run && !seq_busy
      && sleep_instruction
      |=> status_reg[RPM_SLEEP_BIT] && in_sleep)
      else $error("sleep entry missing");
   sleep_clk_a: assert property (@(posedge aclk) disable iff (!aresetn)
      in_sleep |-> !crystal_osc_en && !periph_clk_en && cpu_halt)
      else $error("clock running in sleep");
   sleep_wake_a: assert property (@(posedge aclk) disable iff (!aresetn)
      aclk_en && in_sleep && !hw_rst && irq_pending && irq_wake_capable
      |=> in_run)
      else $error("no wake from sleep");
   sleep_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
      aclk_en && in_sleep && !hw_rst && !irq_wake_capable |=> in_sleep)
      else $error("sleep left without wake source");
   reset_vec_a: assert property (@(posedge aclk) disable iff (!aresetn)
      cpu_reset |-> pc_load && pc_value == RPM_RESET_VEC)
      else $error("reset vector wrong");
   run_clocks_a: assert property (@(posedge aclk) disable iff (!aresetn)
      in_run |-> !cpu_halt && periph_clk_en)
      else $error("run mode not running");
   sleep_wdt_a: assert property (@(posedge aclk) disable iff (!aresetn)
      in_sleep |-> !wdt_rst && !watchdog_irq)
      else $error("watchdog acted in sleep");
   stack_error_flag_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
      aclk_en && stack_error_flag_rst && !hw_rst
      |=> status_reg[RPM_STACK_ERROR_FLAG_BIT] && cpu_reset)
      else $error("stack reset missing");
   pin_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !reset_pin_n |-> cpu_reset && pc_value == RPM_RESET_VEC)
      else $error("pin reset not held");
   quick_skip_a: assert property (@(posedge aclk) disable iff (!aresetn)
      aclk_en && quick_rst && !hw_rst && !seq_busy |=> !seq_busy)
      else $error("quick reset ran start-up count");
   sw_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
      aclk_en && wr_status && !wd[RPM_TOUT_BIT] && !hw_rst && !wdt_rst
      |=> !status_reg[RPM_TOUT_BIT])
      else $error("timeout flag not cleared");
   count_end_a: assert property (@(posedge aclk) disable iff (!aresetn)
      aclk_en && !hw_rst && seq_reg == RPM_WAIT_HS && high_speed_rc_osc_tick
      && cnt_reg == 12'(HS_CYCLES - 1)
      |=> !seq_busy)
      else $error("start-up count did not end");
endmodule : rpm_ctrl

/* File: dv/rpm_osc_model.sv */
`timescale 1ns/10ps
// ----------------------------------------
// rc oscillator tick sources
// ----------------------------------------
module rpm_osc_model #(
   parameter int LS_PER = 8,
   parameter int HS_PER = 4
) (
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic ls_en,
   input  wire logic hs_en,
   output logic      ls_tick,
   output logic      hs_tick
);
   int ls_cnt;
   int hs_cnt;
   // a stopped oscillator gives no tick at all
   assign ls_tick = ls_en && ls_cnt == 0;
   assign hs_tick = hs_en && hs_cnt == 0;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ls_cnt <= 0;
         hs_cnt <= 0;
      end else begin
         ls_cnt <= (ls_cnt + 1) % LS_PER;
         hs_cnt <= (hs_cnt + 1) % HS_PER;
      end
   end
endmodule : rpm_osc_model

/* File: dv/test_reset_and_power_mode_control.sv */
`timescale 1ns/10ps
module test_reset_and_power_mode_control import rpm_pkg::*;;
   localparam int LS = 4, HS = 2, LSP = 8, HSP = 4;
   logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, r;
   logic [1:0]  bresp, rresp;
   logic [3:0]  ev;
   logic        irq, wcap, brown, pin_n, ls_tk, hs_tk, hs_en, ls_en;
   logic        xt_en, pe_en, halt, crst, pcl, wirq;
   logic [12:0] pcv;
   logic        saw_irq, saw_wake, saw_rst;
   logic [33:0] rq[$], bq[$];
   int          fail_count, comparisons, seed, n;

   rpm_ctrl #(.LS_CYCLES(LS), .HS_CYCLES(HS)) u_dut (
      .aclk(aclk), .aresetn(aresetn), .aclk_en(1'b1),
      .s_awaddr(awaddr), .s_awvalid(awvalid), .s_awready(awready),
      .s_wdata(wdata), .s_wstrb(4'hF), .s_wvalid(wvalid),
      .s_wready(wready), .s_bresp(bresp), .s_bvalid(bvalid),
      .s_bready(bready), .s_araddr(araddr), .s_arvalid(arvalid),
      .s_arready(arready), .s_rdata(rdata), .s_rresp(rresp),
      .s_rvalid(rvalid), .s_rready(rready), .idle_instr(ev[0]),
      .sleep_instruction(ev[1]), .irq_pending(irq),
      .irq_wake_capable(wcap), .watchdog_timer_expired(ev[2]),
      .stack_error(ev[3]), .cpu_halt(halt), .cpu_reset(crst),
      .pc_load(pcl), .pc_value(pcv), .watchdog_irq(wirq),
      .brownout_low(brown), .reset_pin_n(pin_n),
      .low_speed_rc_osc_tick(ls_tk), .high_speed_rc_osc_tick(hs_tk),
      .high_speed_rc_osc_en(hs_en), .low_speed_rc_osc_en(ls_en),
      .crystal_osc_en(xt_en), .periph_clk_en(pe_en));
   rpm_osc_model #(.LS_PER(LSP), .HS_PER(HSP)) u_osc (
      .aclk(aclk), .aresetn(aresetn), .ls_en(ls_en), .hs_en(hs_en),
      .ls_tick(ls_tk), .hs_tick(hs_tk));

   initial begin
      aclk = 0;
      forever #4 aclk = ~aclk;
   end
   initial begin
      #200000 fail_count++;
      conclude();
   end
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic check(input logic [33:0] seen, input logic [33:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task conclude;
      $display("checks %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : conclude
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] e = RPM_RESP_OKAY);
      logic aw, w;
      aw = 1;
      w = 1;
      bq.push_back({e, 32'h0});
      @(posedge aclk) {awaddr, wdata} <= {a, d};
      {awvalid, wvalid, bready} <= 3'b111;
      while (aw || w) begin
         @(posedge aclk);
         if (aw && awready) begin
            awvalid <= 1'b0;
            aw = 1'b0;
         end
         if (w && wready) begin
            wvalid <= 1'b0;
            w = 1'b0;
         end
      end
      do @(posedge aclk); while (bvalid !== 1'b1);
      bready <= 0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] e = RPM_RESP_OKAY);
      rq.push_back({e, d});
      @(posedge aclk) {araddr, arvalid, rready} <= {a, 2'b11};
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      rready <= 0;
   endtask : rd
   task automatic pulse(input logic [3:0] m);
      @(posedge aclk) ev <= m;
      @(posedge aclk) ev <= 4'h0;
   endtask : pulse
   task automatic step(input int k);
      repeat (k) @(posedge aclk);
      @(negedge aclk);
   endtask : step
   task automatic clr;
      @(negedge aclk) {saw_irq, saw_wake, saw_rst} = 3'b000;
   endtask : clr
   task automatic wait_rel;
      n = 0;
      do @(posedge aclk) n++; while (crst !== 1'b0 && n < 3000);
      if (crst !== 1'b0) fail_count++;
   endtask : wait_rel
   // ----------------------------------------
   // result watcher
   // ----------------------------------------
   always @(posedge aclk) begin
      if (rvalid && rready)
         check({rresp, rq[0][33:32] == RPM_RESP_OKAY ? rdata : 32'h0},
               rq.pop_front());
      if (bvalid && bready) check({bresp, 32'h0}, bq.pop_front());
      if (wirq) saw_irq <= 1;
      if (pcl && pcv === RPM_IRQ_VEC && !crst) saw_wake <= 1;
      if (crst) saw_rst <= 1;
   end
   initial begin
      seed = 32107;
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, wdata, ev, irq, wcap, brown} = '0;
      {pin_n, saw_irq, saw_wake, saw_rst} = 4'h8;
      repeat (3) @(posedge aclk);
      aresetn <= 1;
      wait_rel();
      rd(RPM_STATUS_OFS, 32'h0);
      rd(RPM_MODE_OFS, 32'h0);
      rd(8'h40, 32'h0, RPM_RESP_SLVERR);
      wr(8'h40, 32'h0, RPM_RESP_SLVERR);
      pulse(4'h1);
      step(2);
      check(34'({halt, pe_en, hs_en}), 34'(3'b111));
      rd(RPM_STATUS_OFS, 32'h20);
      clr();
      pulse(4'h4);
      step(2);
      check(34'({saw_irq, saw_wake, saw_rst, halt}), 34'(4'hC));
      wr(RPM_STATUS_OFS, 32'h0);
      pulse(4'h2);
      step(2);
      check(34'({halt, hs_en, ls_en, xt_en, pe_en}), 34'(5'h10));
      rd(RPM_STATUS_OFS, 32'h80);
      clr();
      pulse(4'h4);
      @(posedge aclk) irq <= 1;
      step(4);
      check(34'({saw_rst, saw_wake, halt}), 34'(3'b001));
      @(posedge aclk) wcap <= 1;
      step(2);
      check(34'({saw_wake, halt, ls_en}), 34'(3'b101));
      @(posedge aclk) {irq, wcap} <= 2'b00;
      wr(RPM_STATUS_OFS, 32'h0);
      clr();
      pulse(4'h4);
      step(2);
      check(34'({saw_rst, halt}), 34'(2'b10));
      rd(RPM_STATUS_OFS, 32'h40);
      rd(RPM_MODE_OFS, 32'h0);
      pulse(4'h8);
      rd(RPM_STATUS_OFS, 32'h44);
      pulse(4'h1);
      clr();
      pulse(4'h8);
      step(2);
      check(34'({saw_rst, halt}), 34'(2'b01));
      rd(RPM_STATUS_OFS, 32'h64);
      pulse(4'h0);
      @(posedge aclk) {irq, pin_n} <= 2'b11;
      @(posedge aclk) {irq, pin_n} <= 2'b00;
      step(3);
      check(34'({crst, pcl, pcv}), 34'({2'b11, RPM_RESET_VEC}));
      @(posedge aclk) pin_n <= 1;
      rd(RPM_MODE_OFS, 32'h8);
      wait_rel();
      rd(RPM_STATUS_OFS, 32'h0);
      @(posedge aclk) brown <= 1;
      step(6);
      check(34'(crst), 34'(1));
      @(posedge aclk) brown <= 0;
      wait_rel();
      check(34'(n >= (LS - 1) * LSP && n <= (LS + 1) * LSP + (HS + 1) * HSP + 4),
            34'(1));
      rd(RPM_STATUS_OFS, 32'h10);
      pulse(4'h8);
      pulse(4'h1);
      @(posedge aclk) pin_n <= 0;
      @(posedge aclk) pin_n <= 1;
      wait_rel();
      rd(RPM_STATUS_OFS, 32'h10);
      rd(RPM_MODE_OFS, 32'h0);
      r = $random(seed);
      wr(RPM_STATUS_OFS, r);
      rd(RPM_STATUS_OFS, {24'h0, 8'h10 & r[7:0]});
      wr(RPM_STATUS_OFS, 32'h0);
      rd(RPM_STATUS_OFS, 32'h0);
      conclude();
   end
endmodule : test_reset_and_power_mode_control
